// ===== design/old_diag.sv
// Open-load diagnostics for five high-side outputs with an APB register slave.
`timescale 1ns/1ps
module old_diag #(
    parameter logic [old_pkg::CNT_W-1:0] FILT_CONV_CYC = old_pkg::FILT_CONV_CYC,
    parameter logic [old_pkg::CNT_W-1:0] LED_WIN_CYC   = old_pkg::LED_WIN_CYC,
    parameter logic [old_pkg::CNT_W-1:0] OFF_TMO_CYC   = old_pkg::OFF_TMO_CYC
) (
    // Clock, reset and APB slave.
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [old_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Power stage and chip select.
    input  wire logic [old_pkg::NCH-1:0]    chan_on,
    input  wire old_pkg::old_sense_t        sense,
    input  wire old_pkg::old_devflt_t       dev_fault,
    input  wire logic                       chip_select_n,
    output old_pkg::old_drive_t             drive
);
    import old_pkg::*;

    old_sense_t           sense_s1_q, sense_s2_q;
    old_devflt_t          dflt_s1_q, dflt_s2_q;
    logic                 csn_s1_q, csn_s2_q, csn_s3_q;
    logic                 cs_rise;

    logic [NCH-1:0]       led_en_q, led_en_d, filt_sel_q, filt_sel_d;
    logic [NCH-1:0]       off_en_q, off_en_d, on_latch_q, on_latch_d;
    logic [NCH-1:0]       off_latch_q, off_latch_d, prev_on_q, prev_on_d;
    logic [NCH-1:0]       forced_q, forced_d, trig_src_q, trig_src_d;
    logic [NCH-1:0]       eff_on, on_cond, quick;
    logic                 trig_q, trig_d, global_open;
    logic [2:0]           dev_latch_q, dev_latch_d;
    logic [31:0]          prdata_q, prdata_d;
    logic                 pready_q, pready_d, pslverr_q, pslverr_d;
    logic                 apb_wr, apb_rd, shutdown_q, shutdown_d;
    logic [CNT_W-1:0]     filt_cnt_q [NCH], filt_cnt_d [NCH];
    logic [CNT_W-1:0]     led_cnt_q [NCH], led_cnt_d [NCH];
    logic [CNT_W-1:0]     off_cnt_q [NCH], off_cnt_d [NCH];
    logic [CNT_W-1:0]     trig_cnt_q, trig_cnt_d, dgl_cnt_q, dgl_cnt_d;
    old_off_st_t          off_st_q [NCH], off_st_d [NCH];
    old_led_st_t          led_st_q [NCH], led_st_d [NCH];
    old_trig_st_t         trig_st_q, trig_st_d;
    old_drive_t           drive_q, drive_d;

    // True when the address selects the status register of channel ch.
    function automatic logic chan_hit(logic [ADDR_W-1:0] addr, int ch);
        return addr == OFS_CHAN0 + ADDR_W'(ch) * OFS_STEP;
    endfunction

    // Every asynchronous input passes two flip-flops before use.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense_s1_q <= '0;
            sense_s2_q <= '0;
            dflt_s1_q  <= '0;
            dflt_s2_q  <= '0;
            csn_s1_q   <= 1'b1;
            csn_s2_q   <= 1'b1;
            csn_s3_q   <= 1'b1;
        end else begin
            sense_s1_q <= sense;
            sense_s2_q <= sense_s1_q;
            dflt_s1_q  <= dev_fault;
            dflt_s2_q  <= dflt_s1_q;
            csn_s1_q   <= chip_select_n;
            csn_s2_q   <= csn_s1_q;
            csn_s3_q   <= csn_s2_q;
        end
    end

    assign cs_rise = csn_s2_q & ~csn_s3_q;
    assign apb_wr  = psel & penable & pready_q & pwrite;
    assign apb_rd  = psel & penable & pready_q & ~pwrite;
    assign quick       = on_latch_q | off_latch_q;
    assign global_open = |quick;

    // Device faults are deglitched before they shut the outputs down.
    always_comb begin
        dgl_cnt_d   = '0;
        shutdown_d  = 1'b0;
        dev_latch_d = dev_latch_q;
        if (|dflt_s2_q) begin
            dgl_cnt_d  = (dgl_cnt_q == FAULT_DGL_CYC) ? dgl_cnt_q : dgl_cnt_q + CNT_ONE;
            shutdown_d = dgl_cnt_d == FAULT_DGL_CYC;
        end
        if (apb_rd && paddr == OFS_DEV) begin
            dev_latch_d = dev_latch_q & ~(prdata_q[DEV_FLAG_LSB +: 3] & ~dflt_s2_q);
        end
        if (shutdown_q) begin
            dev_latch_d = dev_latch_d | dflt_s2_q;
        end
    end

    // Software-visible control bits and the APB answer.
    always_comb begin
        led_en_d   = led_en_q;
        filt_sel_d = filt_sel_q;
        pready_d   = psel & ~penable;
        prdata_d   = prdata_q;
        pslverr_d  = 1'b0;
        if (apb_wr && paddr == OFS_CTRL) begin
            led_en_d   = pwdata[CTRL_LED_EN_LSB +: NCH];
            filt_sel_d = pwdata[CTRL_FILT_LSB +: NCH];
        end
        if (psel && !penable) begin
            prdata_d = READ_ZERO;
            unique case (1'b1)
                paddr == OFS_CTRL: begin
                    prdata_d[CTRL_LED_EN_LSB +: NCH] = led_en_q;
                    prdata_d[CTRL_FILT_LSB +: NCH]   = filt_sel_q;
                    prdata_d[CTRL_TRIG_BIT]          = trig_q;
                end
                paddr == OFS_OFFTEST: prdata_d[NCH-1:0] = off_en_q;
                paddr == OFS_QUICK: begin
                    prdata_d[NCH-1:0]     = quick;
                    prdata_d[GLOBAL_BIT]    = global_open;
                    prdata_d[QUICK_DEV_BIT] = |dev_latch_q;
                end
                paddr == OFS_DEV: begin
                    prdata_d[DEV_FLAG_LSB +: 3] = dev_latch_q;
                    prdata_d[GLOBAL_BIT]        = global_open;
                end
                default: begin
                    pslverr_d = 1'b1;
                    for (int ch = 0; ch < NCH; ch++) begin
                        if (chan_hit(paddr, ch)) begin
                            prdata_d[STAT_ON_BIT]  = on_latch_q[ch];
                            prdata_d[STAT_OFF_BIT] = off_latch_q[ch];
                            prdata_d[GLOBAL_BIT]   = global_open;
                            pslverr_d              = 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    // Full-duty trigger: force selected LED channels off, then hold the source.
    always_comb begin
        trig_d     = trig_q;
        trig_st_d  = trig_st_q;
        trig_cnt_d = trig_cnt_q + CNT_ONE;
        forced_d   = forced_q;
        trig_src_d = trig_src_q;
        unique case (trig_st_q)
            TRIG_IDLE: begin
                trig_cnt_d = '0;
                if (trig_q) begin
                    forced_d   = led_en_q & chan_on;
                    trig_src_d = led_en_q & chan_on;
                    trig_st_d  = TRIG_DETECT;
                end
            end
            TRIG_DETECT: begin
                if (trig_cnt_q == LED_WIN_CYC - CNT_ONE) begin
                    forced_d   = '0;
                    trig_cnt_d = '0;
                    trig_st_d  = TRIG_HOLD;
                end
            end
            TRIG_HOLD: begin
                if (trig_cnt_q == LED_HOLD_CYC - CNT_ONE) begin
                    trig_src_d = '0;
                    trig_d     = 1'b0;
                    trig_st_d  = TRIG_IDLE;
                end
            end
        endcase
        // A software set in the cycle of the self-clear wins.
        if (apb_wr && paddr == OFS_CTRL && pwdata[CTRL_TRIG_BIT]) begin
            trig_d = 1'b1;
        end
    end

    // Per-channel filter, LED evaluation and off-state test; no state is shared.
    always_comb begin
        off_en_d    = off_en_q;
        on_latch_d  = on_latch_q;
        off_latch_d = off_latch_q;
        drive_d     = '0;
        drive_d.fault_shutdown = shutdown_d;
        drive_d.forced_off     = forced_d;
        for (int ch = 0; ch < NCH; ch++) begin
            eff_on[ch]     = chan_on[ch] & ~forced_q[ch];
            prev_on_d[ch]  = eff_on[ch];
            filt_cnt_d[ch] = '0;
            led_cnt_d[ch]  = led_cnt_q[ch] + CNT_ONE;
            led_st_d[ch]   = led_st_q[ch];
            off_cnt_d[ch]  = off_cnt_q[ch] + CNT_ONE;
            off_st_d[ch]   = off_st_q[ch];
            if (eff_on[ch] && !led_en_q[ch] && sense_s2_q.load_low[ch]) begin
                if (filt_cnt_q[ch] != (filt_sel_q[ch] ? FILT_CONV_CYC : FILT_BULB_CYC)) begin
                    filt_cnt_d[ch] = filt_cnt_q[ch] + CNT_ONE;
                end else begin
                    filt_cnt_d[ch] = filt_cnt_q[ch];
                end
            end
            on_cond[ch] = filt_cnt_d[ch] != '0 &&
                          filt_cnt_d[ch] == (filt_sel_q[ch] ? FILT_CONV_CYC : FILT_BULB_CYC);
            if (apb_rd && chan_hit(paddr, ch)) begin
                if (prdata_q[STAT_ON_BIT] && !on_cond[ch]) begin
                    on_latch_d[ch] = 1'b0;
                end
                if (prdata_q[STAT_OFF_BIT]) begin
                    off_latch_d[ch] = 1'b0;
                end
            end
            if (on_cond[ch]) begin
                on_latch_d[ch] = 1'b1;
            end
            unique case (led_st_q[ch])
                LED_IDLE: begin
                    led_cnt_d[ch] = '0;
                    if (led_en_q[ch] && prev_on_q[ch] && !eff_on[ch]) begin
                        led_st_d[ch] = LED_EVAL;
                    end
                end
                LED_EVAL: begin
                    if (!led_en_q[ch] || !sense_s2_q.led_above[ch]) begin
                        led_st_d[ch] = LED_IDLE;
                    end else if (eff_on[ch] || led_cnt_q[ch] == LED_WIN_CYC - CNT_ONE) begin
                        on_latch_d[ch] = 1'b1;
                        led_st_d[ch]   = LED_IDLE;
                    end
                end
            endcase
            unique case (off_st_q[ch])
                OFF_IDLE: begin
                    off_cnt_d[ch] = '0;
                    if (apb_wr && paddr == OFS_OFFTEST) begin
                        off_en_d[ch] = pwdata[ch];
                    end
                    if (cs_rise && off_en_d[ch] && !shutdown_q) begin
                        off_st_d[ch] = OFF_RUN;
                    end
                end
                OFF_RUN: begin
                    if (shutdown_q) begin
                        off_en_d[ch] = 1'b0;
                        off_st_d[ch] = OFF_IDLE;
                    end else if (sense_s2_q.limit_hit[ch]) begin
                        off_en_d[ch] = 1'b0;
                        off_st_d[ch] = OFF_IDLE;
                    end else if (off_cnt_q[ch] == OFF_TMO_CYC - CNT_ONE) begin
                        off_en_d[ch]    = 1'b0;
                        off_latch_d[ch] = 1'b1;
                        off_st_d[ch]    = OFF_IDLE;
                    end
                end
            endcase
            // A separate drive line: overcurrent and sense settings stay untouched.
            drive_d.test_drive_on[ch] = off_st_d[ch] == OFF_RUN;
            drive_d.led_test_current_source[ch] = led_st_d[ch] == LED_EVAL | trig_src_d[ch];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            led_en_q    <= '0;
            filt_sel_q  <= '0;
            off_en_q    <= '0;
            on_latch_q  <= '0;
            off_latch_q <= '0;
            prev_on_q   <= '0;
            forced_q    <= '0;
            trig_src_q  <= '0;
            trig_q      <= 1'b0;
            trig_st_q   <= TRIG_IDLE;
            trig_cnt_q  <= '0;
            dgl_cnt_q   <= '0;
            shutdown_q  <= 1'b0;
            dev_latch_q <= '0;
            prdata_q    <= READ_ZERO;
            pready_q    <= 1'b0;
            pslverr_q   <= 1'b0;
            drive_q     <= '0;
            for (int ch = 0; ch < NCH; ch++) begin
                filt_cnt_q[ch] <= '0;
                led_cnt_q[ch]  <= '0;
                off_cnt_q[ch]  <= '0;
                led_st_q[ch]   <= LED_IDLE;
                off_st_q[ch]   <= OFF_IDLE;
            end
        end else begin
            led_en_q    <= led_en_d;
            filt_sel_q  <= filt_sel_d;
            off_en_q    <= off_en_d;
            on_latch_q  <= on_latch_d;
            off_latch_q <= off_latch_d;
            prev_on_q   <= prev_on_d;
            forced_q    <= forced_d;
            trig_src_q  <= trig_src_d;
            trig_q      <= trig_d;
            trig_st_q   <= trig_st_d;
            trig_cnt_q  <= trig_cnt_d;
            dgl_cnt_q   <= dgl_cnt_d;
            shutdown_q  <= shutdown_d;
            dev_latch_q <= dev_latch_d;
            prdata_q    <= prdata_d;
            pready_q    <= pready_d;
            pslverr_q   <= pslverr_d;
            drive_q     <= drive_d;
            for (int ch = 0; ch < NCH; ch++) begin
                filt_cnt_q[ch] <= filt_cnt_d[ch];
                led_cnt_q[ch]  <= led_cnt_d[ch];
                off_cnt_q[ch]  <= off_cnt_d[ch];
                led_st_q[ch]   <= led_st_d[ch];
                off_st_q[ch]   <= off_st_d[ch];
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign drive   = drive_q;

    for (genvar g = 0; g < NCH; g++) begin : g_chk
        sequence led_off_edge;
            led_st_q[g] == LED_IDLE && led_en_q[g] && prev_on_q[g] && !eff_on[g];
        endsequence
        sequence off_timeout;
            off_st_q[g] == OFF_RUN && off_cnt_q[g] == OFF_TMO_CYC - CNT_ONE &&
                !sense_s2_q.limit_hit[g] && !shutdown_q;
        endsequence
        AST_FILT_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
            !eff_on[g] |=> filt_cnt_q[g] == '0)
            else $error("filter counter kept counting with output low");
        AST_ON_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
            on_cond[g] |=> on_latch_q[g] ##0 global_open)
            else $error("on-state open not latched");
        AST_NO_FORCE: assert property (@(posedge pclk) disable iff (!presetn)
            drive.forced_off[g] |-> trig_st_q != TRIG_IDLE)
            else $error("output forced off outside trigger");
        AST_LED_SRC: assert property (@(posedge pclk) disable iff (!presetn)
            led_off_edge |=> drive.led_test_current_source[g] && led_st_q[g] == LED_EVAL)
            else $error("current source not started at off edge");
        AST_OFF_TMO: assert property (@(posedge pclk) disable iff (!presetn)
            off_timeout |=> off_latch_q[g] && !off_en_q[g] && !drive.test_drive_on[g])
            else $error("off-state timeout not handled");
        AST_OFF_LIMIT: assert property (@(posedge pclk) disable iff (!presetn)
            off_st_q[g] == OFF_RUN && sense_s2_q.limit_hit[g] |=>
                !$rose(off_latch_q[g]) && !off_en_q[g] && !drive.test_drive_on[g])
            else $error("limit reached but test not ended cleanly");
        AST_CS_START: assert property (@(posedge pclk) disable iff (!presetn)
            cs_rise && off_en_q[g] && off_st_q[g] == OFF_IDLE && !shutdown_q &&
                !apb_wr |=> drive.test_drive_on[g] [*2])
            else $error("off-state test did not start on chip select edge");
    end

    AST_TRIG_DONE: assert property (@(posedge pclk) disable iff (!presetn)
        trig_st_q == TRIG_HOLD && trig_cnt_q == LED_HOLD_CYC - CNT_ONE |=>
            !trig_q && trig_src_q == '0)
        else $error("trigger bit not cleared after detection");
    AST_ABORT: assert property (@(posedge pclk) disable iff (!presetn)
        shutdown_q |=> drive.test_drive_on == '0)
        else $error("off-state test not aborted on device fault");
endmodule

// ===== design/old_pkg.sv
// Constants, register map and carrier types of the open-load diagnostic block.
package old_pkg;
    localparam int NCH    = 5;
    localparam int CNT_W  = 17;
    localparam int ADDR_W = 8;
    localparam int CLK_HZ = 40_000_000;

    // Converts a time in seconds into whole clock cycles, rounding up, at least one.
    function automatic int cycles_up(real sec);
        int n;
        n = $rtoi(sec * CLK_HZ);
        if ($itor(n) < sec * CLK_HZ - 1.0e-6) begin
            n = n + 1;
        end
        if (n < 1) begin
            n = 1;
        end
        return n;
    endfunction

    localparam real FILT_BULB_S = 64.0e-6;
    localparam real FILT_CONV_S = 2.0e-3;
    localparam real LED_WIN_S   = 2.0e-3;
    localparam real LED_HOLD_S  = 100.0e-6;
    localparam real OFF_TMO_S   = 1.2e-3;
    localparam real FAULT_DGL_S = 3.3e-6;

    localparam logic [CNT_W-1:0] CNT_ONE       = 17'h00001;
    localparam logic [CNT_W-1:0] FILT_BULB_CYC = CNT_W'(cycles_up(FILT_BULB_S));
    localparam logic [CNT_W-1:0] FILT_CONV_CYC = CNT_W'(cycles_up(FILT_CONV_S));
    localparam logic [CNT_W-1:0] LED_WIN_CYC   = CNT_W'(cycles_up(LED_WIN_S));
    localparam logic [CNT_W-1:0] LED_HOLD_CYC  = CNT_W'(cycles_up(LED_HOLD_S));
    localparam logic [CNT_W-1:0] OFF_TMO_CYC   = CNT_W'(cycles_up(OFF_TMO_S));
    localparam logic [CNT_W-1:0] FAULT_DGL_CYC = CNT_W'(cycles_up(FAULT_DGL_S));

    localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_OFFTEST = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_QUICK   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CHAN0   = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_DEV     = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_STEP    = 8'h04;

    localparam int CTRL_LED_EN_LSB = 0;
    localparam int CTRL_FILT_LSB   = 8;
    localparam int CTRL_TRIG_BIT   = 16;
    localparam int STAT_ON_BIT     = 0;
    localparam int STAT_OFF_BIT    = 1;
    localparam int GLOBAL_BIT      = 8;
    localparam int QUICK_DEV_BIT   = 9;
    localparam int DEV_FLAG_LSB    = 0;

    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic [NCH-1:0] load_low;
        logic [NCH-1:0] led_above;
        logic [NCH-1:0] limit_hit;
    } old_sense_t;

    typedef struct packed {
        logic pump_failure_flag;
        logic undervoltage;
        logic overtemperature_shutdown;
    } old_devflt_t;

    typedef struct packed {
        logic [NCH-1:0] led_test_current_source;
        logic [NCH-1:0] test_drive_on;
        logic [NCH-1:0] forced_off;
        logic           fault_shutdown;
    } old_drive_t;

    typedef enum logic {OFF_IDLE, OFF_RUN} old_off_st_t;
    typedef enum logic {LED_IDLE, LED_EVAL} old_led_st_t;
    typedef enum logic [1:0] {TRIG_IDLE, TRIG_DETECT, TRIG_HOLD} old_trig_st_t;
endpackage

// ===== sim/old_diag_tb_top.sv
// Self-checking bench for the open-load diagnostic block.
`timescale 1ns/1ps
module old_diag_tb_top;
    import old_pkg::*;
    logic           pclk = 1'b0;
    logic           presetn = 1'b0;
    logic           psel = 1'b0;
    logic           penable = 1'b0;
    logic           pwrite = 1'b0;
    logic [7:0]     paddr = 8'h00;
    logic [31:0]    pwdata = 32'h0;
    logic [31:0]    prdata;
    logic [31:0]    rdata;
    logic           pready;
    logic           pslverr;
    logic           resp_err;
    logic           chip_select_n = 1'b1;
    logic [NCH-1:0] chan_on = 5'h00;
    old_sense_t     sense;
    old_devflt_t    dev_fault = 3'h0;
    old_drive_t     drive;
    int             err_total = 0;
    int             cmp_count = 0;
    always #12.5 pclk = ~pclk;
    old_diag #(.FILT_CONV_CYC(17'd40), .LED_WIN_CYC(17'd40), .OFF_TMO_CYC(17'd30)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chan_on(chan_on), .sense(sense), .dev_fault(dev_fault),
        .chip_select_n(chip_select_n), .drive(drive));
    old_load_model load (.pclk(pclk), .chan_on(chan_on), .drive(drive),
        .open_mask(5'h1b), .sense(sense));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata    = prdata;
        resp_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, rdata, exp);
    endtask
    task automatic end_sim;
        $display("Compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #500000;
        err_total++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_QUICK, 32'h0, "quick at reset");
        rd(8'h40, 32'h0, "unmapped data");
        chk("unmapped err", {31'h0, resp_err}, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h0000_1008);
        // Converter filter on channel 4, then LED mode on channel 3.
        chan_on <= 5'h10;
        repeat (60) @(posedge pclk);
        chan_on <= 5'h08;
        repeat (10) @(posedge pclk);
        chan_on <= 5'h00;
        repeat (60) @(posedge pclk);
        chk("led source", {27'h0, drive.led_test_current_source}, 32'h0);
        rd(8'h1c, 32'h101, "conv open");
        rd(8'h1c, 32'h100, "conv cleared");
        rd(8'h18, 32'h101, "led open");
        rd(8'h18, 32'h000, "led cleared");
        // Bulb filter on channel 0 restarts after a short off gap.
        chan_on <= 5'h01;
        repeat (2000) @(posedge pclk);
        chan_on <= 5'h00;
        @(posedge pclk);
        chan_on <= 5'h01;
        repeat (2000) @(posedge pclk);
        rd(OFS_CHAN0, 32'h000, "filter reset");
        repeat (700) @(posedge pclk);
        rd(OFS_QUICK, 32'h101, "quick on");
        rd(OFS_CHAN0, 32'h101, "on held");
        rd(OFS_CHAN0, 32'h101, "still open");
        chk("stays on", {27'h0, drive.forced_off}, 32'h0);
        chan_on <= 5'h00;
        repeat (4) @(posedge pclk);
        rd(OFS_CHAN0, 32'h101, "on last");
        rd(OFS_CHAN0, 32'h000, "on cleared");
        // Off-state tests on channels 1 and 2 start in one frame.
        chip_select_n <= 1'b0;
        apb(1'b1, OFS_OFFTEST, 32'h6);
        chip_select_n <= 1'b1;
        repeat (15) @(posedge pclk);
        rd(OFS_OFFTEST, 32'h2, "limit ends test");
        chip_select_n <= 1'b0;
        apb(1'b1, OFS_OFFTEST, 32'h0);
        chip_select_n <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("no abort", {27'h0, drive.test_drive_on}, 32'h2);
        repeat (60) @(posedge pclk);
        rd(OFS_OFFTEST, 32'h0, "timeout clears");
        rd(OFS_QUICK, 32'h102, "quick off");
        rd(8'h14, 32'h100, "no fault on limit");
        rd(8'h10, 32'h102, "off fault");
        rd(8'h10, 32'h000, "off cleared");
        rd(OFS_QUICK, 32'h0, "global cleared");
        // A device fault during an off-state test aborts it without an open fault.
        dev_fault <= 3'h1;
        repeat (110) @(posedge pclk);
        chip_select_n <= 1'b0;
        apb(1'b1, OFS_OFFTEST, 32'h2);
        chip_select_n <= 1'b1;
        repeat (30) @(posedge pclk);
        chk("fault off", {31'h0, drive.fault_shutdown}, 32'h1);
        chk("aborted", {27'h0, drive.test_drive_on}, 32'h0);
        rd(OFS_OFFTEST, 32'h0, "abort clears");
        rd(OFS_QUICK, 32'h200, "dev in quick");
        dev_fault <= 3'h0;
        repeat (4) @(posedge pclk);
        rd(OFS_DEV, 32'h1, "dev latched");
        rd(OFS_DEV, 32'h0, "dev cleared");
        chk("fault gone", {31'h0, drive.fault_shutdown}, 32'h0);
        // Full-duty trigger on LED channel 3.
        chan_on <= 5'h08;
        repeat (10) @(posedge pclk);
        apb(1'b1, OFS_CTRL, 32'h0001_1008);
        repeat (20) @(posedge pclk);
        chk("trig forced", {27'h0, drive.forced_off}, 32'h8);
        chk("trig source", {27'h0, drive.led_test_current_source}, 32'h8);
        repeat (100) @(posedge pclk);
        chk("re-on", {27'h0, drive.forced_off}, 32'h0);
        chk("source held", {27'h0, drive.led_test_current_source}, 32'h8);
        rd(OFS_CTRL, 32'h0001_1008, "trig pending");
        repeat (4000) @(posedge pclk);
        chk("source off", {27'h0, drive.led_test_current_source}, 32'h0);
        rd(OFS_CTRL, 32'h0000_1008, "trig cleared");
        rd(8'h18, 32'h101, "trig result");
        rd(8'h18, 32'h000, "trig read");
        end_sim();
    end
endmodule

// ===== sim/old_load_model.sv
// Behavioural load model that answers the power stage with sense results.
`timescale 1ns/1ps
module old_load_model (
    // Clock.
    input  wire logic                    pclk,
    // Power stage view and loads that are missing.
    input  wire logic [old_pkg::NCH-1:0] chan_on,
    input  wire old_pkg::old_drive_t     drive,
    input  wire logic [old_pkg::NCH-1:0] open_mask,
    // Sense results.
    output old_pkg::old_sense_t          sense
);
    import old_pkg::*;
    logic [NCH-1:0] hi_q = '0;
    initial sense = '0;
    // A missing load draws no current and leaves the output high when sourced.
    // A driven output stays above the comparator for one sample after switch-off.
    always @(posedge pclk) begin
        hi_q            <= chan_on & ~drive.forced_off;
        sense.load_low  <= chan_on & open_mask;
        sense.led_above <= (chan_on & ~drive.forced_off) | hi_q |
                           (drive.led_test_current_source & open_mask);
        sense.limit_hit <= drive.test_drive_on & ~open_mask;
    end
endmodule
